// File: core/boot_remap_pkg.sv
`default_nettype none
package boot_remap_pkg;
    // Boot modes, as latched from the select straps.
    localparam logic [1:0] MODE_USER = 2'h0;
    localparam logic [1:0] MODE_SYS = 2'h1;
    localparam logic [1:0] MODE_RAM = 2'h2;
    localparam logic [1:0] MODE_EXT = 2'h3;
    // Main regions, from the top three address bits.
    localparam logic [2:0] BLK_BOOT = 3'h0;
    localparam logic [2:0] BLK_RAM = 3'h1;
    localparam logic [2:0] BLK_FLASH = 3'h2;
    localparam logic [2:0] BLK_EXT = 3'h3;
    localparam logic [2:0] BLK_RSVD = 3'h4;
    // Access sizes.
    localparam logic [1:0] SZ_BYTE = 2'h0;
    localparam logic [1:0] SZ_HALF = 2'h1;
    localparam logic [1:0] SZ_WORD = 2'h2;
    // Register offsets.
    localparam logic [7:0] REG_BOOT = 8'h00;
    localparam logic [7:0] REG_PWR = 8'h04;
    localparam logic [7:0] REG_FCR0 = 8'h08;
    localparam logic [7:0] REG_WPROT = 8'h0C;
    localparam logic [3:0] REG_BCON_HI = 4'h1;
    localparam logic [7:0] REG_STAT = 8'h20;
    // Field positions.
    localparam int BURST_BIT = 0;
    localparam int PWD_BIT = 0;
    localparam int BCON_W16 = 4;
    localparam int BCON_EN = 5;
    // Reset values.
    localparam logic [5:0] BCON0_RST = 6'h3F;
    localparam logic [5:0] BCON_RST = 6'h1F;
    localparam logic [3:0] WPROT_RST = 4'h0;
    // Flash offset fields, in 16K pages of bits 20:14.
    localparam logic [6:0] FL_BANK1_PG = 7'h30;
    localparam logic [6:0] FL_SYSMEM_PG = 7'h20;
    // Timing.
    localparam int CLK_MHZ = 20;
    localparam int WAKE_US = 20;
    localparam int WAKE_CYC = WAKE_US * CLK_MHZ;
    localparam logic [1:0] STRAP_EDGE = 2'h1;
    localparam logic [1:0] STRAP_DONE = 2'h2;
endpackage
`default_nettype wire

// File: core/boot_remap.sv
// Strobed register access and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
module boot_remap (
    // Clock and reset.
    input wire logic clk,
    input wire logic nrst,
    // Boot straps.
    input wire logic boot_strap_enable,
    input wire logic [1:0] boot_select,
    // Power events and flash bank programming state.
    input wire logic stop_mode,
    input wire logic wake_event,
    input wire logic [1:0] flash_bank_busy,
    // CPU bus request.
    input wire logic bus_req,
    input wire logic bus_write,
    input wire logic bus_seq,
    input wire logic [1:0] bus_size,
    input wire logic [31:0] bus_addr,
    // Register port.
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Memory selects.
    output logic [2:0] region,
    output logic ram_sel,
    output logic [15:0] ram_addr,
    output logic [3:0] ram_be,
    output logic flash_sel,
    output logic flash_reg_sel,
    output logic flash_bank,
    output logic [2:0] flash_sector,
    output logic [20:0] flash_offset,
    output logic periph_sel,
    output logic bus_error,
    output logic bus_stall,
    output logic [6:0] wait_states,
    // External memory port.
    output logic [23:0] ext_addr,
    output logic [3:0] bank_select_n,
    output logic read_strobe_n,
    output logic [1:0] write_enable_n,
    // CPU clock gate.
    output logic cpu_clk_enable
);
    typedef enum logic [1:0] {ST_RUN, ST_STOP, ST_WAKE} pwr_e;

    // Bank 0 opens with four 8K sectors in its low 32K, then one 32K and three 64K sectors.
    function automatic logic [2:0] sector_of(input logic [17:0] off);
        if (off[17:15] == 3'h0) begin
            sector_of = {1'b0, off[14:13]};
        end else if (off[17:16] == 2'h0) begin
            sector_of = 3'h4;
        end else begin
            sector_of = 3'(3'h4 + {1'b0, off[17:16]});
        end
    endfunction

    logic [1:0] rst_cnt;
    logic [1:0] strap_mode;
    logic [1:0] boot_remap_control;
    logic flash_burst_select;
    logic flash_powerdown_bit;
    logic [3:0] wprot;
    logic [5:0] bank_cfg [4];
    pwr_e state;
    pwr_e next_state;
    logic [8:0] wake_cnt;

    // Strap capture.
    wire capture = rst_cnt == boot_remap_pkg::STRAP_EDGE;
    wire [1:0] next_strap = boot_strap_enable ? boot_select : boot_remap_pkg::MODE_USER;
    // Re-presenting the system pattern stretches the clock again.
    wire freeze_now = strap_mode == boot_remap_pkg::MODE_SYS && boot_strap_enable
        && boot_select == boot_remap_pkg::MODE_SYS;
    wire sys_boot = strap_mode == boot_remap_pkg::MODE_SYS;

    // Register decode.
    wire wr_boot = reg_wr && reg_addr == boot_remap_pkg::REG_BOOT;
    wire wr_pwr = reg_wr && reg_addr == boot_remap_pkg::REG_PWR;
    wire wr_fcr0 = reg_wr && reg_addr == boot_remap_pkg::REG_FCR0;
    wire wr_wprot = reg_wr && reg_addr == boot_remap_pkg::REG_WPROT;
    wire bcon_hit = reg_addr[7:4] == boot_remap_pkg::REG_BCON_HI && reg_addr[1:0] == 2'h0;

    // Address map.
    wire [2:0] blk = bus_addr[31:29];
    wire [2:0] alias_blk = boot_remap_control == boot_remap_pkg::MODE_RAM ? boot_remap_pkg::BLK_RAM
        : boot_remap_control == boot_remap_pkg::MODE_EXT ? boot_remap_pkg::BLK_EXT
        : boot_remap_pkg::BLK_FLASH;
    wire [2:0] eff = blk == boot_remap_pkg::BLK_BOOT ? alias_blk : blk;
    wire is_ram = eff == boot_remap_pkg::BLK_RAM;
    wire is_flash = eff == boot_remap_pkg::BLK_FLASH;
    wire is_ext = eff == boot_remap_pkg::BLK_EXT;
    wire is_periph = eff[2] && eff != boot_remap_pkg::BLK_RSVD;

    // RAM: 64K, aligned byte, half and word.
    wire ram_in = bus_addr[28:16] == 13'h0000;
    wire ram_misalign = (bus_size == boot_remap_pkg::SZ_HALF && bus_addr[0])
        || (bus_size == boot_remap_pkg::SZ_WORD && bus_addr[1:0] != 2'h0)
        || bus_size == 2'h3;
    wire [3:0] next_be = bus_size == boot_remap_pkg::SZ_BYTE ? 4'h1 << bus_addr[1:0]
        : bus_size == boot_remap_pkg::SZ_HALF ? (bus_addr[1] ? 4'hC : 4'h3)
        : 4'hF;

    // Flash.
    wire [20:0] foff = bus_addr[20:0];
    wire fl_low = bus_addr[28:21] == 8'h00;
    wire fl_b0 = fl_low && foff[20:18] == 3'h0;
    wire fl_b1 = fl_low && foff[20:14] == boot_remap_pkg::FL_BANK1_PG;
    wire fl_sys = fl_low && foff[20:14] == boot_remap_pkg::FL_SYSMEM_PG;
    wire fl_reg = fl_low && foff[20] && foff[19:16] == 4'h0;
    wire [2:0] sect = fl_b1 ? {2'h0, foff[13]} : sector_of(foff[17:0]);
    wire fl_prot = fl_b0 && bus_write && !sect[2] && wprot[sect[1:0]] && !sys_boot;
    wire fl_deny = fl_sys && !sys_boot;
    // The factory area decodes as flash; only the latched strap mode decides who reaches it.
    wire fl_ok = (fl_b0 || fl_b1 || fl_reg || fl_sys) && !fl_prot;
    wire fl_busy = (fl_b0 && flash_bank_busy[0]) || (fl_b1 && flash_bank_busy[1]);
    // Burst off means low-power flash: zero waits, CPU clock limited to 33 MHz.
    wire [6:0] fl_wait = (flash_burst_select && !bus_seq) ? 7'h01 : 7'h00;

    // External memory.
    wire [1:0] xb = bus_addr[28:27];
    wire [5:0] xcfg = bank_cfg[xb];
    wire x_w16 = xcfg[boot_remap_pkg::BCON_W16] || xb == 2'h0;
    wire x_ok = xcfg[boot_remap_pkg::BCON_EN] && bus_size != 2'h3;
    wire [6:0] x_pieces = x_w16 ? (bus_size == boot_remap_pkg::SZ_WORD ? 7'h02 : 7'h01)
        : (bus_size == boot_remap_pkg::SZ_WORD ? 7'h04
        : bus_size == boot_remap_pkg::SZ_HALF ? 7'h02 : 7'h01);
    wire [6:0] x_single = {3'h0, xcfg[3:0]} + (bus_write ? 7'h01 : 7'h02);
    wire [6:0] x_wait = 7'(x_single * x_pieces);
    wire [1:0] x_lanes = !x_w16 ? 2'h1
        : bus_size == boot_remap_pkg::SZ_BYTE ? (bus_addr[0] ? 2'h2 : 2'h1) : 2'h3;

    wire next_err = (is_ram && (!ram_in || ram_misalign))
        || (is_flash && (fl_deny || !fl_ok))
        || (is_ext && !x_ok)
        || eff == boot_remap_pkg::BLK_RSVD;

    wire [31:0] stat_word = {28'h0, cpu_clk_enable, state == pwr_e'(ST_RUN), strap_mode};
    wire [31:0] bcon_word = {26'h0, bank_cfg[reg_addr[3:2]]};
    wire [31:0] next_rdata = reg_addr == boot_remap_pkg::REG_BOOT ? {30'h0, boot_remap_control}
        : reg_addr == boot_remap_pkg::REG_PWR ? {31'h0, flash_burst_select}
        : reg_addr == boot_remap_pkg::REG_FCR0 ? {31'h0, flash_powerdown_bit}
        : reg_addr == boot_remap_pkg::REG_WPROT ? {28'h0, wprot}
        : reg_addr == boot_remap_pkg::REG_STAT ? stat_word
        : bcon_hit ? bcon_word : 32'h0;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rst_cnt <= 2'h0;
        end else if (rst_cnt != boot_remap_pkg::STRAP_DONE) begin
            rst_cnt <= rst_cnt + 2'h1;
        end
    end

    // Straps are taken once, after release; they never reset-load the flop.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            strap_mode <= boot_remap_pkg::MODE_USER;
        end else if (capture) begin
            strap_mode <= next_strap;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            boot_remap_control <= boot_remap_pkg::MODE_USER;
        end else if (capture) begin
            boot_remap_control <= next_strap;
        end else if (wr_boot) begin
            boot_remap_control <= reg_wdata[1:0];
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            flash_burst_select <= 1'b0;
            flash_powerdown_bit <= 1'b0;
            wprot <= boot_remap_pkg::WPROT_RST;
        end else begin
            if (wr_pwr) begin
                flash_burst_select <= reg_wdata[boot_remap_pkg::BURST_BIT];
            end
            if (wr_fcr0) begin
                flash_powerdown_bit <= reg_wdata[boot_remap_pkg::PWD_BIT];
            end
            if (wr_wprot) begin
                wprot <= reg_wdata[3:0];
            end
        end
    end

    for (genvar i = 0; i < 4; i++) begin : g_bcon
        always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
                bank_cfg[i] <= i == 0 ? boot_remap_pkg::BCON0_RST : boot_remap_pkg::BCON_RST;
            end else if (reg_wr && bcon_hit && reg_addr[3:2] == 2'(i)) begin
                bank_cfg[i] <= reg_wdata[5:0];
            end
        end
    end

    always_comb begin
        next_state = state;
        unique case (state)
            ST_RUN: begin
                if (stop_mode) begin
                    next_state = ST_STOP;
                end
            end
            ST_STOP: begin
                if (wake_event) begin
                    next_state = flash_powerdown_bit ? ST_WAKE : ST_RUN;
                end
            end
            ST_WAKE: begin
                if (wake_cnt == 9'h000) begin
                    next_state = ST_RUN;
                end
            end
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state <= ST_RUN;
            wake_cnt <= 9'h000;
        end else begin
            state <= next_state;
            if (state == ST_STOP) begin
                wake_cnt <= 9'(boot_remap_pkg::WAKE_CYC - 1);
            end else if (wake_cnt != 9'h000) begin
                wake_cnt <= wake_cnt - 9'h001;
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cpu_clk_enable <= 1'b0;
            reg_rdata <= 32'h0;
        end else begin
            cpu_clk_enable <= !freeze_now && next_state == ST_RUN
                && rst_cnt == boot_remap_pkg::STRAP_DONE;
            reg_rdata <= reg_rd ? next_rdata : 32'h0;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            region <= 3'h0;
            ram_sel <= 1'b0;
            ram_addr <= 16'h0000;
            ram_be <= 4'h0;
            flash_sel <= 1'b0;
            flash_reg_sel <= 1'b0;
            flash_bank <= 1'b0;
            flash_sector <= 3'h0;
            flash_offset <= 21'h0;
            periph_sel <= 1'b0;
            bus_error <= 1'b0;
            bus_stall <= 1'b0;
            wait_states <= 7'h00;
            ext_addr <= 24'h0;
            bank_select_n <= 4'hF;
            read_strobe_n <= 1'b1;
            write_enable_n <= 2'h3;
        end else begin
            region <= eff;
            ram_addr <= bus_addr[15:0];
            ram_be <= next_be;
            flash_offset <= foff;
            flash_bank <= fl_b1;
            flash_sector <= sect;
            ext_addr <= bus_addr[23:0];
            ram_sel <= bus_req && is_ram && !next_err;
            flash_sel <= bus_req && is_flash && !next_err && !fl_reg;
            flash_reg_sel <= bus_req && is_flash && fl_reg && !fl_deny;
            periph_sel <= bus_req && is_periph;
            bus_error <= bus_req && next_err;
            bus_stall <= bus_req && is_flash && !next_err && fl_busy;
            wait_states <= !bus_req ? 7'h00 : is_flash ? fl_wait
                : (is_ext && x_ok) ? x_wait : 7'h00;
            bank_select_n <= (bus_req && is_ext && x_ok) ? ~(4'h1 << xb) : 4'hF;
            read_strobe_n <= !(bus_req && is_ext && x_ok && !bus_write);
            write_enable_n <= (bus_req && is_ext && x_ok && bus_write) ? ~x_lanes : 2'h3;
        end
    end

    strap_capture_a: assert property (@(posedge clk) disable iff (!nrst)
        capture |=> strap_mode == $past(next_strap))
        else $error("strap not latched on second edge");
    user_ignore_a: assert property (@(posedge clk) disable iff (!nrst)
        capture && !boot_strap_enable |=> strap_mode == boot_remap_pkg::MODE_USER)
        else $error("select straps not ignored");
    mode_hold_a: assert property (@(posedge clk) disable iff (!nrst)
        rst_cnt == 2'h2 |=> $stable(strap_mode))
        else $error("latched mode changed");
    clock_freeze_a: assert property (@(posedge clk) disable iff (!nrst)
        freeze_now |=> !cpu_clk_enable)
        else $error("cpu clock ran while frozen");
    remap_now_a: assert property (@(posedge clk) disable iff (!nrst)
        wr_boot && !capture && reg_wdata[1:0] == boot_remap_pkg::MODE_RAM
        ##1 blk == boot_remap_pkg::BLK_BOOT |=> region == boot_remap_pkg::BLK_RAM)
        else $error("remap not immediate");
    ram_word_a: assert property (@(posedge clk) disable iff (!nrst)
        bus_req && is_ram && !next_err && bus_size == boot_remap_pkg::SZ_WORD
        |=> ram_sel && ram_be == 4'hF)
        else $error("word access lanes wrong");
    ram_alias_a: assert property (@(posedge clk) disable iff (!nrst)
        bus_req && blk == boot_remap_pkg::BLK_BOOT
        && boot_remap_control != boot_remap_pkg::MODE_RAM |=> !ram_sel)
        else $error("RAM seen at zero outside RAM mapping");
    flash_alias_a: assert property (@(posedge clk) disable iff (!nrst)
        blk == boot_remap_pkg::BLK_BOOT
        && (boot_remap_control == boot_remap_pkg::MODE_USER
        || boot_remap_control == boot_remap_pkg::MODE_SYS) |=> region == boot_remap_pkg::BLK_FLASH)
        else $error("flash not seen at zero");
    write_prot_a: assert property (@(posedge clk) disable iff (!nrst)
        bus_req && is_flash && fl_b0 && bus_write && bus_addr[17:15] == 3'h0
        && wprot[bus_addr[14:13]] && !sys_boot |=> bus_error && !flash_sel)
        else $error("protected sector written");
    bank_apart_a: assert property (@(posedge clk) disable iff (!nrst)
        bus_req && is_flash && fl_b1 && flash_bank_busy == 2'h1 |=> flash_sel && !bus_stall)
        else $error("bank 1 held by bank 0 work");
    low_power_a: assert property (@(posedge clk) disable iff (!nrst)
        bus_req && is_flash && !flash_burst_select |=> wait_states == 7'h00)
        else $error("wait inserted in low-power flash");
    burst_seq_a: assert property (@(posedge clk) disable iff (!nrst)
        bus_req && is_flash && flash_burst_select && bus_seq |=> wait_states == 7'h00)
        else $error("sequential burst access waited");
    ext_read_a: assert property (@(posedge clk) disable iff (!nrst)
        bus_req && is_ext && x_ok && !bus_write |=> !read_strobe_n && write_enable_n == 2'h3)
        else $error("external read strobes wrong");
    ext_select_a: assert property (@(posedge clk) disable iff (!nrst)
        bus_req && is_ext && x_ok |=> bank_select_n == ~(4'h1 << $past(xb)) && !bus_error)
        else $error("wrong external bank select");
    burst_wait_a: assert property (@(posedge clk) disable iff (!nrst)
        bus_req && is_flash && flash_burst_select && !bus_seq |=> wait_states == 7'h01)
        else $error("non-sequential burst wait wrong");
    sys_deny_a: assert property (@(posedge clk) disable iff (!nrst)
        bus_req && is_flash && fl_sys && !sys_boot |=> bus_error && !flash_sel)
        else $error("system area reachable");
    wake_delay_a: assert property (@(posedge clk) disable iff (!nrst)
        state == ST_STOP && wake_event && flash_powerdown_bit |=> !cpu_clk_enable [*8])
        else $error("cpu restarted before flash wake");
    wake_fast_a: assert property (@(posedge clk) disable iff (!nrst)
        state == ST_STOP && wake_event && !flash_powerdown_bit && !freeze_now
        |=> cpu_clk_enable)
        else $error("delay inserted without power-down");
endmodule // boot_remap
`default_nettype wire

// File: verification/strap_board_model.sv
`timescale 1ns/1ps
`default_nettype none
module strap_board_model (
    // Clock and reset.
    input wire logic clk,
    input wire logic nrst,
    // Levels the bench wants on the straps.
    input wire logic want_en,
    input wire logic [1:0] want_sel,
    // Device side.
    input wire logic cpu_clk_enable,
    output logic boot_strap_enable,
    output logic [1:0] boot_select
);
    logic dropped;
    logic clk_seen;
    // Straps are plain levels held steady across the capture edge.
    assign boot_select = want_sel;
    assign boot_strap_enable = want_en & ~dropped;
    // Once the CPU clock restarts the board pulls enable low, so a repeated
    // select pattern cannot freeze the clock again.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            dropped <= 1'b0;
            clk_seen <= 1'b0;
        end else begin
            clk_seen <= cpu_clk_enable;
            if (cpu_clk_enable && !clk_seen)
                dropped <= 1'b1;
        end
    end
endmodule // strap_board_model
`default_nettype wire

// File: verification/boot_remap_tb.sv
`timescale 1ns/1ps
`default_nettype none
module boot_remap_tb;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic want_en = 1'b0;
    logic [1:0] want_sel = 2'h0;
    logic stop_mode = 1'b0;
    logic wake_event = 1'b0;
    logic [1:0] flash_bank_busy = 2'h0;
    logic bus_req = 1'b0;
    logic bus_write = 1'b0;
    logic bus_seq = 1'b0;
    logic [1:0] bus_size = 2'h0;
    logic [31:0] bus_addr = 32'h0;
    logic [7:0] reg_addr = 8'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    wire logic [31:0] reg_rdata;
    wire logic [2:0] region;
    wire logic ram_sel, flash_sel, flash_reg_sel, flash_bank, periph_sel;
    wire logic bus_error, bus_stall, read_strobe_n, cpu_clk_enable;
    wire logic boot_strap_enable;
    wire logic [1:0] boot_select, write_enable_n;
    wire logic [15:0] ram_addr;
    wire logic [3:0] ram_be, bank_select_n;
    wire logic [2:0] flash_sector;
    wire logic [20:0] flash_offset;
    wire logic [6:0] wait_states;
    wire logic [23:0] ext_addr;
    int fails = 0;
    int compares = 0;

    always #25 clk = ~clk;

    strap_board_model board_u (.clk(clk), .nrst(nrst), .want_en(want_en),
        .want_sel(want_sel), .cpu_clk_enable(cpu_clk_enable),
        .boot_strap_enable(boot_strap_enable), .boot_select(boot_select));

    boot_remap dut_u (.clk(clk), .nrst(nrst), .boot_strap_enable(boot_strap_enable),
        .boot_select(boot_select), .stop_mode(stop_mode), .wake_event(wake_event),
        .flash_bank_busy(flash_bank_busy), .bus_req(bus_req), .bus_write(bus_write),
        .bus_seq(bus_seq), .bus_size(bus_size), .bus_addr(bus_addr),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .region(region), .ram_sel(ram_sel), .ram_addr(ram_addr),
        .ram_be(ram_be), .flash_sel(flash_sel), .flash_reg_sel(flash_reg_sel),
        .flash_bank(flash_bank), .flash_sector(flash_sector),
        .flash_offset(flash_offset), .periph_sel(periph_sel), .bus_error(bus_error),
        .bus_stall(bus_stall), .wait_states(wait_states), .ext_addr(ext_addr),
        .bank_select_n(bank_select_n), .read_strobe_n(read_strobe_n),
        .write_enable_n(write_enable_n), .cpu_clk_enable(cpu_clk_enable));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wrap_up();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic do_reset(input logic en, input logic [1:0] sel);
        want_en <= en;
        want_sel <= sel;
        nrst <= 1'b0;
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        repeat (4) @(posedge clk);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    // Read data stands one cycle only, so it is sampled just after that edge.
    task automatic rd(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata & mask, exp);
    endtask

    task automatic acc(input logic [31:0] a, input logic w, input logic [1:0] sz,
                       input logic sq);
        @(posedge clk);
        bus_addr <= a;
        bus_write <= w;
        bus_size <= sz;
        bus_seq <= sq;
        bus_req <= 1'b1;
        @(posedge clk);
        bus_req <= 1'b0;
        #1;
    endtask

    task automatic user_map();
        do_reset(1'b0, 2'h3);
        rd(8'h20, 32'h3, 32'h0);
        chk(cpu_clk_enable, 1);
        acc(32'h0, 0, 2'h2, 0);
        chk({flash_sel, bus_error, 1'b0, region}, {3'h4, boot_remap_pkg::BLK_FLASH});
        acc(32'hA000_0000, 0, 2'h2, 0);
        chk(region, 3'h5);
        acc(32'h8000_0000, 0, 2'h2, 0);
        chk(bus_error, 1);
        acc(32'hC000_1000, 0, 2'h2, 0);
        chk({periph_sel, 1'b0, region}, {2'h2, 3'h6});
    endtask

    task automatic ram_map();
        acc(32'h0000_0010, 0, 2'h2, 0);
        chk(ram_sel, 0);
        wr(boot_remap_pkg::REG_BOOT, 32'h2);
        acc(32'h0000_0010, 0, 2'h2, 0);
        chk({ram_sel, region, ram_addr}, {1'b1, boot_remap_pkg::BLK_RAM, 16'h0010});
        acc(32'h2000_FFFD, 1, 2'h0, 0);
        chk({ram_sel, ram_be}, {1'b1, 4'h2});
        acc(32'h2000_0002, 0, 2'h1, 0);
        chk({ram_sel, ram_be}, {1'b1, 4'hC});
        acc(32'h0000_0004, 1, 2'h2, 0);
        chk({ram_sel, ram_be}, {1'b1, 4'hF});
        acc(32'h2000_0001, 0, 2'h1, 0);
        chk({ram_sel, bus_error}, 2'h1);
        acc(32'h2001_0000, 0, 2'h0, 0);
        chk(bus_error, 1);
    endtask

    task automatic ext_map();
        wr(boot_remap_pkg::REG_BOOT, 32'h3);
        acc(32'h0000_0000, 0, 2'h2, 0);
        chk({bank_select_n, region}, {4'hE, boot_remap_pkg::BLK_EXT});
        acc(32'h6012_3454, 0, 2'h2, 0);
        chk({bank_select_n, read_strobe_n, wait_states}, {4'hE, 1'b0, 7'd34});
        chk(ext_addr, 24'h123454);
        acc(32'h6000_0002, 1, 2'h1, 0);
        chk({write_enable_n, read_strobe_n, wait_states}, {2'h0, 1'b1, 7'd16});
        acc(32'h6800_0000, 0, 2'h2, 0);
        chk({bus_error, bank_select_n}, {1'b1, 4'hF});
        wr(8'h14, 32'h20);
        acc(32'h6800_0000, 0, 2'h2, 0);
        chk({bank_select_n, read_strobe_n, wait_states}, {4'hD, 1'b0, 7'd8});
        acc(32'h7800_0000, 0, 2'h2, 0);
        chk(bus_error, 1);
        wr(boot_remap_pkg::REG_BOOT, 32'h0);
    endtask

    task automatic flash_map();
        logic [31:0] offs [5] = '{32'h6000, 32'h8000, 32'h1_0000, 32'hC_0000, 32'hC_2000};
        logic [3:0] exp [5] = '{4'h3, 4'h4, 4'h5, 4'h8, 4'h9};
        foreach (offs[i]) begin
            acc(32'h4000_0000 | offs[i], 0, 2'h2, 0);
            chk({flash_sel, flash_bank, flash_sector}, {1'b1, exp[i]});
        end
        acc(32'h4010_0008, 0, 2'h2, 0);
        chk({flash_reg_sel, flash_sel, 3'h0, flash_offset}, {5'h10, 21'h10_0008});
        wr(boot_remap_pkg::REG_PWR, 32'h0);
        acc(32'h4000_0100, 0, 2'h2, 0);
        chk(wait_states, 0);
        wr(boot_remap_pkg::REG_PWR, 32'h1);
        acc(32'h4000_0100, 0, 2'h2, 0);
        chk(wait_states, 1);
        acc(32'h4000_0104, 0, 2'h2, 1);
        chk(wait_states, 0);
        wr(boot_remap_pkg::REG_WPROT, 32'h1);
        acc(32'h4000_0000, 1, 2'h2, 0);
        chk({flash_sel, bus_error}, 2'h1);
        acc(32'h4000_8000, 1, 2'h2, 0);
        chk({flash_sel, bus_error}, 2'h2);
        acc(32'h4008_0000, 0, 2'h2, 0);
        chk(bus_error, 1);
        flash_bank_busy <= 2'h1;
        acc(32'h400C_0000, 0, 2'h2, 0);
        chk({flash_sel, bus_stall}, 2'h2);
        acc(32'h4000_0000, 0, 2'h2, 0);
        chk(bus_stall, 1);
        flash_bank_busy <= 2'h0;
    endtask

    // Counts cycles from the wake pulse until the CPU clock runs again.
    task automatic stop_wake(input logic pd, input int lo, input int hi);
        int n;
        wr(boot_remap_pkg::REG_FCR0, {31'h0, pd});
        stop_mode <= 1'b1;
        for (n = 0; n < 20 && cpu_clk_enable !== 1'b0; n++)
            @(posedge clk);
        stop_mode <= 1'b0;
        @(posedge clk);
        wake_event <= 1'b1;
        @(posedge clk);
        wake_event <= 1'b0;
        for (n = 0; n < 600 && cpu_clk_enable !== 1'b1; n++)
            @(posedge clk);
        chk(n >= lo && n <= hi, 1);
    endtask

    task automatic sys_boot();
        int n;
        do_reset(1'b1, 2'h1);
        repeat (20) @(posedge clk);
        chk(cpu_clk_enable, 0);
        rd(8'h20, 32'h3, 32'h1);
        wr(boot_remap_pkg::REG_WPROT, 32'h1);
        acc(32'h4000_0000, 1, 2'h2, 0);
        chk(bus_error, 0);
        want_sel <= 2'h0;
        for (n = 0; n < 10 && cpu_clk_enable !== 1'b1; n++)
            @(posedge clk);
        chk(cpu_clk_enable, 1);
        rd(8'h20, 32'h3, 32'h1);
        do_reset(1'b1, 2'h2);
        want_sel <= 2'h3;
        acc(32'h0000_0000, 0, 2'h2, 0);
        chk({ram_sel, region}, {1'b1, boot_remap_pkg::BLK_RAM});
    endtask

    initial begin
        user_map();
        ram_map();
        ext_map();
        flash_map();
        stop_wake(1'b0, 0, 2);
        stop_wake(1'b1, boot_remap_pkg::WAKE_CYC, boot_remap_pkg::WAKE_CYC + 4);
        sys_boot();
        wrap_up();
    end

    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        wrap_up();
    end
endmodule // boot_remap_tb
`default_nettype wire
